// ### pkg/fac_pkg.sv
package fac_pkg;

	// ************************************************************
	// register map (byte addresses on the avalon bus)
	// ************************************************************
	localparam logic [31:0] FAC_ADDR_ECC_ERR   = 32'hFFFFF8A0; // first flash error address
	localparam logic [31:0] FAC_ADDR_ERR_FLAG  = 32'hFFFFF8A4; // error interrupt flag register
	localparam logic [31:0] FAC_ADDR_PROTECT   = 32'hFFFFF8A8; // protection prohibit bits
	localparam logic [31:0] FAC_ADDR_PROT_KEY  = 32'hFFFFF8AC; // protected sequence key
	localparam logic [31:0] FAC_ADDR_DED_ROUTE = 32'hFFFFF8B0; // double error routing
	localparam logic [31:0] FAC_ADDR_DF_CTL    = 32'hFFFFFCF8; // data flash control

	// ************************************************************
	// field layout and reset values
	// ************************************************************
	localparam int          FAC_ERR_ADDR_LSB = 2;
	localparam int          FAC_ERR_ADDR_MSB = 18;
	localparam logic [31:0] FAC_ECC_ERR_RST  = 32'h00000000;
	localparam logic [7:0]  FAC_DF_CTL_RST   = 8'h00;
	localparam int          FAC_DF_EN_BIT    = 7;
	localparam int          FAC_PROT_CHIP    = 0;
	localparam int          FAC_PROT_BLOCK   = 1;
	localparam int          FAC_PROT_PROG    = 2;
	localparam int          FAC_PROT_READ    = 3;
	localparam int          FAC_PROT_BOOT    = 4;
	localparam int          FAC_PROT_W       = 5;
	localparam logic [7:0]  FAC_PROT_KEY     = 8'hA5;
	localparam logic [15:0] FAC_DED_EXC_CODE = 16'h0080;

	// ************************************************************
	// code flash and data flash geometry
	// ************************************************************
	localparam int          FAC_CF_ADDR_W    = 19;
	localparam int          FAC_CF_BLOCK_LSB = 12;      // 4 KB erase blocks
	localparam int          FAC_CF_BLOCKS    = 128;
	localparam int          FAC_BLK_W        = 7;
	localparam int          FAC_BOOT_BLOCKS  = 8;
	localparam int          FAC_UNIT_LSB     = 3;       // 8 byte rewrite units
	localparam int          FAC_DF_ADDR_W    = 26;
	localparam logic [25:0] FAC_DF_FIRST     = 26'h3E00000;
	localparam logic [25:0] FAC_DF_LAST      = 26'h3E07FFF;
	localparam int          FAC_DF_BLOCK_LSB = 11;      // 2 KB erase blocks
	localparam int          FAC_DF_BLOCK_W   = 4;       // 16 blocks of 2 KB in 32 KB
	localparam int          FAC_ECC_W        = 7;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef enum logic [2:0] {
		FAC_OP_NONE,
		FAC_OP_CHIP_ERASE,
		FAC_OP_BLOCK_ERASE,
		FAC_OP_PROGRAM,
		FAC_OP_READ
	} fac_op_t;

	typedef struct packed {
		fac_op_t     op;
		logic [18:0] addr;
		logic [7:0]  count;
	} fac_cmd_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [31:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} fac_avs_req_t;

	typedef struct packed {
		logic        valid;
		logic [18:0] addr;
		logic [31:0] data;
		logic [6:0]  ecc;
	} fac_rd_t;

	typedef struct packed {
		logic                         ser_meta;
		logic                         ser_sync;
		logic                         avs_wait;
		logic [31:0]                  avs_rdata;
		logic [16:0]                  err_addr;
		logic                         err_flag;
		logic [7:0]                   df_ctl;
		logic [FAC_PROT_W-1:0]        protect;
		logic                         key_armed;
		logic                         ded_route;
		logic [FAC_CF_BLOCKS-1:0]     erased;
		logic                         cmd_accept;
		logic                         cmd_refuse;
		fac_cmd_t                     cmd;
		logic                         df_erase_all;
		logic                         rd_valid;
		logic [31:0]                  rd_data;
		logic [6:0]                   wr_ecc;
		logic                         ded_nmi;
		logic                         ded_irq;
		logic [15:0]                  ded_code;
		logic                         df_sel;
		logic                         df_refuse;
		logic [FAC_DF_BLOCK_W-1:0]    df_block;
	} fac_state_t;

endpackage

// ### hdl/fac_flash_access.sv
// Overview of operation
// - each 4 KB code flash block can be erased on its own.
// - one erase request may cover 1 to 128 adjacent blocks inside the array.
// - chip-erase prohibit refuses chip and block erase in serial programming.
// - chip erase keeps the boot cluster protection flag.
// - block-erase prohibit refuses block erase in serial programming only.
// - program prohibit refuses block erase and rewrite in serial programming.
// - read prohibit refuses the read command in serial programming.
// - boot rewrite prohibit blocks erase and writing of boot cluster, both modes.
// - after erase, rewrite in 8 byte units with low three address bits zero.
// - a 7-bit ECC is kept with each 32-bit code flash word.
// - single-bit errors corrected silently, double errors raise an event.
// - double error goes out as NMI or maskable interrupt code 0080.
// - error address register holds address bits 18..2, others zero.
// - capture of the first error address sets the flash error flag.
// - while flag is set, no new capture and no new event.
// - any reset clears the error address register to zero.
// - data flash is 32 KB in 2 KB blocks, written in 32-bit steps.
// - data flash answers at 3E00000 through 3E07FFF.
// - data flash control bit 7 gates reads, reset value 00.
// - data flash control writes only via the protected key sequence.
module fac_flash_access
	import fac_pkg::*;
(
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rstn,
	// register bus
	input  wire fac_avs_req_t              i_avs,
	output logic [31:0]                    o_avs_readdata,
	output logic                           o_avs_waitrequest,
	// flash commands
	input  wire logic                      i_serial_mode,
	input  wire logic                      i_cmd_valid,
	input  wire fac_cmd_t                  i_cmd,
	input  wire logic [31:0]               i_wr_data,
	output logic                           o_cmd_accept,
	output logic                           o_cmd_refuse,
	output fac_cmd_t                       o_cmd,
	output logic                           o_df_erase_all,
	output logic [6:0]                     o_wr_ecc,
	// code flash array read path
	input  wire fac_rd_t                   i_rd,
	output logic                           o_rd_valid,
	output logic [31:0]                    o_rd_data,
	output logic                           o_ded_nmi,
	output logic                           o_ded_irq,
	output logic [15:0]                    o_ded_code,
	// data flash accesses from the memory bus controller
	input  wire logic                      i_df_req,
	input  wire logic                      i_df_write,
	input  wire logic [FAC_DF_ADDR_W-1:0]  i_df_addr,
	output logic                           o_df_sel,
	output logic                           o_df_refuse,
	output logic [FAC_DF_BLOCK_W-1:0]      o_df_block
);

	// ************************************************************
	// ecc helpers
	// ************************************************************

	// check bits over data placed at non power of two positions
	function automatic logic [6:0] ecc_gen(input logic [31:0] d);
		logic [6:0] c;
		int         p;
		c = '0;
		p = 3;
		for (int i = 0; i < 32; i++) begin
			if ((p & (p - 1)) == 0) begin
				p = p + 1;
			end
			for (int j = 0; j < 6; j++) begin
				if (((p >> j) & 1) == 1) begin
					c[j] = c[j] ^ d[i];
				end
			end
			p = p + 1;
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction

	// returns {double error, corrected data}
	function automatic logic [32:0] ecc_fix(input logic [31:0] d, input logic [6:0] e);
		logic [6:0]  c;
		logic [5:0]  syn;
		logic        par;
		logic [31:0] fixed;
		int          p;
		c     = ecc_gen(d);
		syn   = c[5:0] ^ e[5:0];
		par   = ^{d, e};
		fixed = d;
		p     = 3;
		for (int i = 0; i < 32; i++) begin
			if ((p & (p - 1)) == 0) begin
				p = p + 1;
			end
			if (par && (p == int'(syn))) begin
				fixed[i] = ~d[i];
			end
			p = p + 1;
		end
		return {((syn != 6'h00) && !par), fixed};
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	fac_state_t state_q;
	fac_state_t state_d;

	// decode terms of the next state logic
	logic                     serial;
	logic                     req;
	logic                     commit_wr;
	logic                     clear_req;
	logic                     flag_eff;
	logic [32:0]              fix;
	logic [FAC_BLK_W-1:0]     blk;
	logic [8:0]               blk_end;
	logic [FAC_CF_BLOCKS-1:0] in_range;
	logic [FAC_CF_BLOCKS-1:0] boot_mask;
	logic                     range_bad;
	logic                     hits_boot;
	logic                     refuse;
	logic                     df_in_win;
	logic                     df_ok;
	logic [31:0]              rd_mux;

	// block range decode for erase requests
	always_comb begin
		blk       = i_cmd.addr[FAC_CF_ADDR_W-1:FAC_CF_BLOCK_LSB];
		blk_end   = {2'b00, blk} + {1'b0, i_cmd.count};
		range_bad = (i_cmd.count == 8'h00) || (blk_end > 9'(FAC_CF_BLOCKS));
	end

	// per block membership of the erase range and of the boot cluster
	for (genvar b = 0; b < FAC_CF_BLOCKS; b++) begin : g_blk
		assign in_range[b]  = (9'(b) >= {2'b00, blk}) && (9'(b) < blk_end);
		assign boot_mask[b] = (b < FAC_BOOT_BLOCKS);
	end

	// an erase that touches any boot block
	assign hits_boot = |(in_range & boot_mask);

	// register read multiplexer
	always_comb begin
		case (i_avs.address)
			FAC_ADDR_ECC_ERR:   rd_mux = {13'h0000, state_q.err_addr, 2'b00};
			FAC_ADDR_ERR_FLAG:  rd_mux = {31'h00000000, state_q.err_flag};
			FAC_ADDR_PROTECT:   rd_mux = {27'h0000000, state_q.protect};
			FAC_ADDR_DED_ROUTE: rd_mux = {31'h00000000, state_q.ded_route};
			FAC_ADDR_DF_CTL:    rd_mux = {24'h000000, state_q.df_ctl};
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		state_d = state_q;
		serial  = state_q.ser_sync;

		// serial mode pin synchroniser
		state_d.ser_meta = i_serial_mode;
		state_d.ser_sync = state_q.ser_meta;

		// one-cycle outputs fall back each cycle
		state_d.cmd_accept   = 1'b0;
		state_d.cmd_refuse   = 1'b0;
		state_d.df_erase_all = 1'b0;
		state_d.ded_nmi      = 1'b0;
		state_d.ded_irq      = 1'b0;
		state_d.ded_code     = 16'h0000;
		state_d.df_sel       = 1'b0;
		state_d.df_refuse    = 1'b0;

		// avalon slave: answer one cycle after the request, commit on the handshake
		// every completed access drops the key, so it opens only the next access
		req       = i_avs.read | i_avs.write;
		commit_wr = 1'b0;
		clear_req = 1'b0;
		if (req && state_q.avs_wait) begin
			state_d.avs_wait  = 1'b0;
			state_d.avs_rdata = rd_mux;
		end else if (req) begin
			state_d.avs_wait  = 1'b1;
			state_d.key_armed = 1'b0;
			commit_wr         = i_avs.write & i_avs.byteenable[0];
		end

		// register writes
		// byte lane 0 must be enabled, every writable field sits in it
		if (commit_wr) begin
			case (i_avs.address)
				FAC_ADDR_PROT_KEY: begin
					state_d.key_armed = (i_avs.writedata[7:0] == FAC_PROT_KEY);
				end
				FAC_ADDR_DF_CTL: begin
					if (state_q.key_armed) begin
						state_d.df_ctl = i_avs.writedata[7:0];
					end
				end
				FAC_ADDR_ERR_FLAG: begin
					clear_req = i_avs.writedata[0];                              // write 1 clears
				end
				FAC_ADDR_PROTECT: begin
					// protections can be added but never removed by software
					state_d.protect = state_q.protect | i_avs.writedata[FAC_PROT_W-1:0];
				end
				FAC_ADDR_DED_ROUTE: begin
					state_d.ded_route = i_avs.writedata[0];
				end
				default: begin
				end
			endcase
		end

		// ecc check and correction of array reads
		fix              = ecc_fix(i_rd.data, i_rd.ecc);
		state_d.rd_valid = i_rd.valid;
		state_d.rd_data  = fix[31:0];
		state_d.wr_ecc   = ecc_gen(i_wr_data);

		// first error capture; an event in the clear cycle is kept
		// the flag guards the first address until software clears it
		flag_eff = state_q.err_flag & ~clear_req;
		if (clear_req) begin
			state_d.err_flag = 1'b0;
		end
		if (i_rd.valid && fix[32] && !flag_eff) begin
			state_d.err_addr = i_rd.addr[FAC_ERR_ADDR_MSB:FAC_ERR_ADDR_LSB];
			state_d.err_flag = 1'b1;
			state_d.ded_nmi  = state_q.ded_route;
			state_d.ded_irq  = ~state_q.ded_route;
			state_d.ded_code = FAC_DED_EXC_CODE;
		end

		// flash command screening
		// self-programming ignores every prohibit except the boot cluster one
		refuse = 1'b0;
		if (i_cmd_valid) begin
			case (i_cmd.op)
				FAC_OP_CHIP_ERASE: begin
					refuse = (serial && state_q.protect[FAC_PROT_CHIP])
					      || state_q.protect[FAC_PROT_BOOT];
				end
				FAC_OP_BLOCK_ERASE: begin
					refuse = range_bad
					      || (serial && state_q.protect[FAC_PROT_CHIP])
					      || (serial && state_q.protect[FAC_PROT_BLOCK])
					      || (serial && state_q.protect[FAC_PROT_PROG])
					      || (state_q.protect[FAC_PROT_BOOT] && hits_boot);
				end
				FAC_OP_PROGRAM: begin
					refuse = (i_cmd.addr[FAC_UNIT_LSB-1:0] != 3'b000)
					      || !state_q.erased[blk]
					      || (serial && state_q.protect[FAC_PROT_PROG])
					      || (state_q.protect[FAC_PROT_BOOT] && boot_mask[blk]);
				end
				FAC_OP_READ: begin
					refuse = serial && state_q.protect[FAC_PROT_READ];
				end
				default: begin
					refuse = 1'b1;
				end
			endcase
			state_d.cmd_accept = ~refuse;
			state_d.cmd_refuse = refuse;
			state_d.cmd        = i_cmd;
		end

		// effects of accepted erase commands
		// a chip erase takes the data flash with it
		if (i_cmd_valid && !refuse) begin
			case (i_cmd.op)
				FAC_OP_CHIP_ERASE: begin
					state_d.erased       = '1;
					state_d.df_erase_all = 1'b1;
					// extra area erased, boot cluster protection flag survives
					state_d.protect      = state_q.protect & (5'h01 << FAC_PROT_BOOT);
				end
				FAC_OP_BLOCK_ERASE: begin
					state_d.erased = state_q.erased | in_range;
				end
				default: begin
				end
			endcase
		end

		// data flash window, read gate and word-aligned writes
		// accesses outside the window belong to other devices and get no answer
		df_in_win = (i_df_addr >= FAC_DF_FIRST) && (i_df_addr <= FAC_DF_LAST);
		df_ok     = i_df_write ? (i_df_addr[1:0] == 2'b00)
		                       : state_q.df_ctl[FAC_DF_EN_BIT];
		if (i_df_req && df_in_win) begin
			state_d.df_sel    = df_ok;
			state_d.df_refuse = ~df_ok;
			state_d.df_block  = i_df_addr[FAC_DF_BLOCK_LSB+FAC_DF_BLOCK_W-1:FAC_DF_BLOCK_LSB];
		end
	end

	// state register; reset clears capture and control registers
	// the bus idles with waitrequest high, so every request is answered one cycle later and committed in the following handshake cycle
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q          <= '0;
			state_q.avs_wait <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	// register bus answer
	assign o_avs_readdata    = state_q.avs_rdata;
	assign o_avs_waitrequest = state_q.avs_wait;

	// command screening results
	assign o_cmd_accept      = state_q.cmd_accept;
	assign o_cmd_refuse      = state_q.cmd_refuse;
	assign o_cmd             = state_q.cmd;
	assign o_df_erase_all    = state_q.df_erase_all;

	// check bits for the word being programmed
	assign o_wr_ecc          = state_q.wr_ecc;

	// corrected read data and double error events
	assign o_rd_valid        = state_q.rd_valid;
	assign o_rd_data         = state_q.rd_data;
	assign o_ded_nmi         = state_q.ded_nmi;
	assign o_ded_irq         = state_q.ded_irq;
	assign o_ded_code        = state_q.ded_code;

	// data flash answer
	assign o_df_sel          = state_q.df_sel;
	assign o_df_refuse       = state_q.df_refuse;
	assign o_df_block        = state_q.df_block;

endmodule // fac_flash_access

// ### test/fac_flash_model.sv
module fac_flash_model
	import fac_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_req,
	input  wire logic [18:0] i_addr,
	input  wire logic [31:0] i_data,
	input  wire logic [38:0] i_flip,
	output fac_rd_t          o_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// code flash array read port
	// ****************
	logic [38:0] last_q = 39'h0;
	// hamming check bits, top bit is overall even parity
	function automatic logic [6:0] ecc_of(input logic [31:0] d);
		int         p;
		logic [6:0] e;
		e = 7'h00;
		p = 3;
		for (int i = 0; i < 32; i++) begin
			while ((p & (p - 1)) == 0) p++;
			for (int k = 0; k < 6; k++) if (p[k]) e[k] = e[k] ^ d[i];
			p++;
		end
		e[6] = ^{d, e[5:0]};
		return e;
	endfunction
	// stored word with its code, plus the bit errors the bench orders
	wire [38:0] word = {ecc_of(i_data), i_data} ^ i_flip;
	// released lines show the inverse of the last word
	always_ff @(posedge i_clk_sys) if (i_req) last_q <= word;
	assign o_rd.valid = i_req;
	assign o_rd.addr = i_req ? i_addr : ~i_addr;
	assign {o_rd.ecc, o_rd.data} = i_req ? word : ~last_q;
endmodule // fac_flash_model

// ### test/fac_flash_access_properties.sv
module fac_flash_access_properties
	import fac_pkg::*;
(
	input wire logic                      i_clk_sys,
	input wire logic                      i_rstn,
	input wire logic                      i_cmd_valid,
	input wire fac_cmd_t                  i_cmd,
	input wire logic                      o_cmd_accept,
	input wire logic                      o_cmd_refuse,
	input wire fac_cmd_t                  o_cmd,
	input wire logic                      o_df_erase_all,
	input wire fac_rd_t                   i_rd,
	input wire logic                      o_rd_valid,
	input wire logic                      o_ded_nmi,
	input wire logic                      o_ded_irq,
	input wire logic [15:0]               o_ded_code,
	input wire logic                      i_df_req,
	input wire logic                      i_df_write,
	input wire logic [FAC_DF_ADDR_W-1:0]  i_df_addr,
	input wire logic                      o_df_sel,
	input wire logic                      o_df_refuse,
	input wire logic [FAC_DF_BLOCK_W-1:0] o_df_block
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	// ****************
	// helpers
	// ****************
	wire in_win = i_df_req && i_df_addr >= FAC_DF_FIRST && i_df_addr <= FAC_DF_LAST;
	wire ded = o_ded_nmi || o_ded_irq;
	sequence s_cmd_answer;
		##1 (o_cmd_accept ^ o_cmd_refuse);
	endsequence
	sequence s_df_answer;
		##1 (o_df_sel ^ o_df_refuse);
	endsequence
	// ****************
	// properties
	// ****************
	a_cmd_answered: assert property (i_cmd_valid |-> s_cmd_answer)
		else $error("command not answered once");
	a_no_stray_answer: assert property (!i_cmd_valid |=> !o_cmd_accept && !o_cmd_refuse)
		else $error("answer without command");
	a_prog_aligned: assert property (i_cmd_valid && i_cmd.op == FAC_OP_PROGRAM
		&& i_cmd.addr[2:0] != 3'h0 |=> o_cmd_refuse) else $error("misaligned program taken");
	a_chip_df_erase: assert property (o_df_erase_all |-> o_cmd_accept
		&& o_cmd.op == FAC_OP_CHIP_ERASE) else $error("data flash erase without chip erase");
	a_ded_code_set: assert property (ded |-> o_ded_code == 16'h0080 && !(o_ded_nmi && o_ded_irq))
		else $error("bad double error code");
	a_ded_code_idle: assert property (!ded |-> o_ded_code == 16'h0000)
		else $error("code without event");
	a_ded_from_read: assert property (ded |-> o_rd_valid && $past(i_rd.valid))
		else $error("event without read");
	a_rd_latency: assert property (i_rd.valid |=> o_rd_valid)
		else $error("read not answered");
	a_df_outside: assert property (i_df_req && !in_win |=> !o_df_sel && !o_df_refuse)
		else $error("answer outside window");
	a_df_block: assert property (in_win |-> s_df_answer ##0 o_df_block == $past(i_df_addr[14:11]))
		else $error("bad data flash block");
	a_df_wr_align: assert property (in_win && i_df_write && i_df_addr[1:0] != 2'h0 |=> o_df_refuse)
		else $error("misaligned write taken");
endmodule // fac_flash_access_properties
bind fac_flash_access fac_flash_access_properties chk_u (.i_clk_sys, .i_rstn, .i_cmd_valid, .i_cmd,
	.o_cmd_accept, .o_cmd_refuse, .o_cmd, .o_df_erase_all, .i_rd, .o_rd_valid, .o_ded_nmi,
	.o_ded_irq, .o_ded_code, .i_df_req, .i_df_write, .i_df_addr, .o_df_sel, .o_df_refuse, .o_df_block);

// ### test/tb_flash_ecc_and_access_control.sv
module tb_flash_ecc_and_access_control
	import fac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys, i_rstn, i_serial_mode, i_cmd_valid, o_cmd_accept, o_cmd_refuse, o_df_erase_all;
	logic o_avs_waitrequest, o_rd_valid, o_ded_nmi, o_ded_irq, i_df_req, i_df_write, o_df_sel;
	logic o_df_refuse, rd_req;
	logic [31:0] o_avs_readdata, i_wr_data, o_rd_data, rd_data;
	logic [25:0] i_df_addr;
	logic [18:0] rd_addr;
	logic [38:0] flip;
	logic [15:0] o_ded_code;
	logic [6:0] o_wr_ecc;
	logic [3:0] o_df_block;
	fac_avs_req_t i_avs;
	fac_cmd_t i_cmd, o_cmd;
	fac_rd_t i_rd;
	int fail_count, compares, cycles;
	fac_flash_access dut_u (.i_clk_sys, .i_rstn, .i_avs, .o_avs_readdata, .o_avs_waitrequest,
		.i_serial_mode, .i_cmd_valid, .i_cmd, .i_wr_data, .o_cmd_accept, .o_cmd_refuse, .o_cmd,
		.o_df_erase_all, .o_wr_ecc, .i_rd, .o_rd_valid, .o_rd_data, .o_ded_nmi, .o_ded_irq,
		.o_ded_code, .i_df_req, .i_df_write, .i_df_addr, .o_df_sel, .o_df_refuse, .o_df_block);
	fac_flash_model flash_u (.i_clk_sys, .i_req(rd_req), .i_addr(rd_addr), .i_data(rd_data),
		.i_flip(flip), .o_rd(i_rd));
	// ****************
	// shared tasks
	// ****************
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk_sys);
		i_avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
		do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs <= '0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask
	task automatic cmd(input fac_op_t op, input logic [18:0] a, input logic [7:0] n, input logic ok);
		@(posedge i_clk_sys);
		i_cmd_valid <= 1'b1;
		i_cmd <= '{op: op, addr: a, count: n};
		@(posedge i_clk_sys);
		i_cmd_valid <= 1'b0;
		#1;
		chk("command accept", {31'h0, ok}, {31'h0, o_cmd_accept});
		chk("command refuse", {31'h0, !ok}, {31'h0, o_cmd_refuse});
	endtask
	task automatic df(input logic [25:0] a, input logic w, input logic [1:0] exp);
		@(posedge i_clk_sys);
		i_df_req <= 1'b1;
		i_df_addr <= a;
		i_df_write <= w;
		@(posedge i_clk_sys);
		i_df_req <= 1'b0;
		#1;
		chk("data flash answer", {30'h0, exp}, {30'h0, o_df_sel, o_df_refuse});
		if (exp[1]) chk("data flash block", {28'h0, a[14:11]}, {28'h0, o_df_block});
	endtask
	task automatic ecc_rd(input logic [18:0] a, input logic [38:0] f, input logic [1:0] exp);
		@(posedge i_clk_sys);
		rd_req <= 1'b1;
		rd_addr <= a;
		rd_data <= 32'h5A3C96E1 ^ {13'h0, a};
		flip <= f;
		@(posedge i_clk_sys);
		rd_req <= 1'b0;
		#1;
		// a double error cannot be repaired, the word comes back with both flipped bits
		chk("read word", ($countones(f) > 1) ? rd_data ^ f[31:0] : rd_data, o_rd_data);
		chk("double error route", {30'h0, exp}, {30'h0, o_ded_nmi, o_ded_irq});
	endtask
	task automatic set_mode(input logic s);
		@(posedge i_clk_sys);
		i_serial_mode <= s;
		repeat (3) @(posedge i_clk_sys);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_regs_and_df();
		rd_chk("error address", FAC_ADDR_ECC_ERR, 32'h0);
		rd_chk("data flash control", FAC_ADDR_DF_CTL, 32'h0);
		rd_chk("unmapped", 32'hFFFFF8C0, 32'h0);
		df(26'h3E00000, 1'b0, 2'b01);
		wr(FAC_ADDR_DF_CTL, 32'h80);
		rd_chk("unkeyed write", FAC_ADDR_DF_CTL, 32'h0);
		wr(FAC_ADDR_PROT_KEY, 32'hA5);
		wr(FAC_ADDR_DF_CTL, 32'h80);
		rd_chk("keyed write", FAC_ADDR_DF_CTL, 32'h80);
		df(26'h3E00000, 1'b0, 2'b10);
		df(26'h3E07FFC, 1'b0, 2'b10);
		df(26'h3E08000, 1'b0, 2'b00);
		df(26'h3DFFFFC, 1'b0, 2'b00);
		df(26'h3E00802, 1'b1, 2'b01);
		df(26'h3E00804, 1'b1, 2'b10);
	endtask
	task automatic t_commands();
		set_mode(1'b1);
		wr(FAC_ADDR_PROTECT, 32'h08);
		cmd(FAC_OP_CHIP_ERASE, 19'h0, 8'h0, 1'b1);
		rd_chk("protect after erase", FAC_ADDR_PROTECT, 32'h0);
		cmd(FAC_OP_BLOCK_ERASE, 19'h0A000, 8'h1, 1'b1);
		cmd(FAC_OP_PROGRAM, 19'h0A008, 8'h0, 1'b1);
		cmd(FAC_OP_PROGRAM, 19'h0A004, 8'h0, 1'b0);
		cmd(FAC_OP_READ, 19'h00100, 8'h0, 1'b1);
		wr(FAC_ADDR_PROTECT, 32'h08);
		cmd(FAC_OP_READ, 19'h00100, 8'h0, 1'b0);
		wr(FAC_ADDR_PROTECT, 32'h02);
		cmd(FAC_OP_BLOCK_ERASE, 19'h0C000, 8'h1, 1'b0);
		wr(FAC_ADDR_PROTECT, 32'h04);
		cmd(FAC_OP_PROGRAM, 19'h0A010, 8'h0, 1'b0);
		wr(FAC_ADDR_PROTECT, 32'h01);
		cmd(FAC_OP_CHIP_ERASE, 19'h0, 8'h0, 1'b0);
		wr(FAC_ADDR_PROTECT, 32'h10);
		set_mode(1'b0);
		cmd(FAC_OP_READ, 19'h00100, 8'h0, 1'b1);
		cmd(FAC_OP_BLOCK_ERASE, 19'h0C000, 8'h3, 1'b1);
		cmd(FAC_OP_BLOCK_ERASE, 19'h7F000, 8'h2, 1'b0);
		cmd(FAC_OP_PROGRAM, 19'h0C008, 8'h0, 1'b1);
		cmd(FAC_OP_BLOCK_ERASE, 19'h07000, 8'h1, 1'b0);
		cmd(FAC_OP_PROGRAM, 19'h00008, 8'h0, 1'b0);
		cmd(FAC_OP_BLOCK_ERASE, 19'h08000, 8'h1, 1'b1);
	endtask
	task automatic t_ecc();
		@(posedge i_clk_sys);
		i_wr_data <= 32'hC3A50F1E;
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk("write code", {25'h0, flash_u.ecc_of(32'hC3A50F1E)}, {25'h0, o_wr_ecc});
		ecc_rd(19'h01000, 39'h20, 2'b00);
		ecc_rd(19'h01004, 39'h08_0000_0000, 2'b00);
		ecc_rd(19'h1234F, 39'h201, 2'b01);
		rd_chk("first address", FAC_ADDR_ECC_ERR, 32'h0001234C);
		rd_chk("error flag", FAC_ADDR_ERR_FLAG, 32'h1);
		ecc_rd(19'h00400, 39'h201, 2'b00);
		rd_chk("held address", FAC_ADDR_ECC_ERR, 32'h0001234C);
		wr(FAC_ADDR_ERR_FLAG, 32'h1);
		wr(FAC_ADDR_DED_ROUTE, 32'h1);
		ecc_rd(19'h7FFFC, 39'h201, 2'b10);
		rd_chk("second address", FAC_ADDR_ECC_ERR, 32'h0007FFFC);
		@(posedge i_clk_sys);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		rd_chk("address after reset", FAC_ADDR_ECC_ERR, 32'h0);
		rd_chk("flag after reset", FAC_ADDR_ERR_FLAG, 32'h0);
		rd_chk("control after reset", FAC_ADDR_DF_CTL, 32'h0);
	endtask
	// ****************
	// clock, timeout and main sequence
	// ****************
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// cut a hang short
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end
	// reset, then run every scenario
	initial begin
		{i_rstn, i_serial_mode, i_cmd_valid, i_df_req, i_df_write, rd_req} = 6'h00;
		{i_avs, i_cmd, i_wr_data, i_df_addr, rd_addr, rd_data, flip} = '0;
		repeat (12) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		t_regs_and_df();
		t_commands();
		t_ecc();
		conclude();
	end
endmodule // tb_flash_ecc_and_access_control
